// [src/sar_adc_pkg.sv]
/*
 * Constants of the four-channel successive-approximation converter control:
 * register indexes and byte addresses, field positions, reset values and the
 * conversion-time table counted in peripheral clock ticks.
 * Assumes a 32-bit APB register bus, one register to an aligned word.
 */
package sar_adc_pkg;

    // ------------------------------------------------------------------
    // register indexes (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [15:0] IDX_RESULT_WIDE = 16'hff18;
    localparam logic [15:0] IDX_RESULT_HIGH = 16'hff1a;
    localparam logic [15:0] IDX_PORT_DIR    = 16'hff22;
    localparam logic [15:0] IDX_MODE        = 16'hff80;
    localparam logic [15:0] IDX_CHAN        = 16'hff81;
    localparam logic [15:0] IDX_PORT_FUNC   = 16'hff84;

    localparam int          ADDR_W           = 18;
    localparam logic [17:0] ADDR_RESULT_WIDE = {IDX_RESULT_WIDE, 2'b00};
    localparam logic [17:0] ADDR_RESULT_HIGH = {IDX_RESULT_HIGH, 2'b00};
    localparam logic [17:0] ADDR_PORT_DIR    = {IDX_PORT_DIR, 2'b00};
    localparam logic [17:0] ADDR_MODE        = {IDX_MODE, 2'b00};
    localparam logic [17:0] ADDR_CHAN        = {IDX_CHAN, 2'b00};
    localparam logic [17:0] ADDR_PORT_FUNC   = {IDX_PORT_FUNC, 2'b00};

    // ------------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------------
    localparam int         MODE_RUN_BIT   = 7;
    localparam int         MODE_FR_LSB    = 3;
    localparam int         MODE_BOOST_BIT = 0;
    localparam logic [7:0] MODE_RST       = 8'h00;
    localparam logic [7:0] CHAN_RST       = 8'h00;
    localparam logic [7:0] PORT_FUNC_RST  = 8'h00;
    localparam logic [7:0] PORT_DIR_RST   = 8'hff;

    // ------------------------------------------------------------------
    // timing: clock rates and conversion table in peripheral ticks
    // ------------------------------------------------------------------
    localparam int CORE_CLK_MHZ = 250;
    localparam int FXP_MHZ      = 10;
    localparam int FXP_DIV      = CORE_CLK_MHZ / FXP_MHZ;
    localparam int RESULT_BITS  = 10;

    localparam logic [7:0] SAMPLE_TICKS [8] = '{8'h0c, 8'h18, 8'h30, 8'h58,
                                                8'h18, 8'h30, 8'h60, 8'hb0};
    localparam logic [7:0] TOTAL_TICKS  [8] = '{8'h24, 8'h30, 8'h48, 8'h70,
                                                8'h48, 8'h60, 8'h90, 8'he0};

    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_CONVERT = 2'b11
    } conv_state_e;

endpackage

// [src/sar_adc_sequencer.sv]
/*
 * Control logic of a four-channel 10-bit successive-approximation converter
 * with its APB register file, sequencer and shared-pin function control.
 * Assumes an external comparator that reports input >= ladder tap, and a
 * ladder tap selector that follows O_TAP directly.
 */
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer #(
    parameter int FXP_DIV = sar_adc_pkg::FXP_DIV
) (
    input  wire logic        I_CORE_CLK,
    input  wire logic        I_NRST,
    input  wire logic        I_PSEL,
    input  wire logic        I_PENABLE,
    input  wire logic        I_PWRITE,
    input  wire logic [17:0] I_PADDR,
    input  wire logic [31:0] I_PWDATA,
    input  wire logic [3:0]  I_PSTRB,
    output logic      [31:0] O_PRDATA,
    output logic             O_PREADY,
    output logic             O_PSLVERR,
    input  wire logic        I_CMP_GE,
    output logic      [9:0]  O_TAP,
    output logic             O_SAMPLE,
    output logic      [1:0]  O_CHANNEL,
    output logic             O_REF_ENABLE,
    output logic             O_CONV_DONE,
    output logic      [3:0]  O_PIN_ANALOG,
    output logic      [3:0]  O_PIN_OUT_EN
);

    // ------------------------------------------------------------------
    // peripheral clock enable
    // ------------------------------------------------------------------
    logic [7:0] div_cnt;
    logic [7:0] next_div_cnt;
    logic       tick;

    // divider gives one enable pulse per peripheral clock period
    always_comb begin
        tick         = (div_cnt == 8'(FXP_DIV - 1));
        next_div_cnt = tick ? 8'h00 : div_cnt + 8'h01;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= next_div_cnt;
        end
    end

    // ------------------------------------------------------------------
    // register file and APB slave
    // ------------------------------------------------------------------
    logic        mode_run;
    logic [2:0]  mode_fr;
    logic        mode_boost;
    logic [1:0]  chan;
    logic [3:0]  func;
    logic [3:0]  dir;
    logic [9:0]  result;
    logic        next_mode_run;
    logic [2:0]  next_mode_fr;
    logic        next_mode_boost;
    logic [1:0]  next_chan;
    logic [3:0]  next_func;
    logic [3:0]  next_dir;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic [3:0]  next_pin_oe;
    logic        setup;
    logic        wr_ok;
    logic        hit_mode;
    logic        hit_chan;
    logic        ctl_write;
    logic        new_run;

    // decode; a write lands only at the access edge with the low lane on
    always_comb begin
        setup     = I_PSEL && !I_PENABLE;
        wr_ok     = I_PSEL && I_PENABLE && O_PREADY && I_PWRITE && I_PSTRB[0];
        hit_mode  = (I_PADDR == sar_adc_pkg::ADDR_MODE);
        hit_chan  = (I_PADDR == sar_adc_pkg::ADDR_CHAN);
        ctl_write = wr_ok && (hit_mode || hit_chan);
        new_run   = (wr_ok && hit_mode) ? I_PWDATA[sar_adc_pkg::MODE_RUN_BIT] : mode_run;
    end

    // register writes and read data prepared in the setup phase
    always_comb begin
        next_mode_run   = mode_run;
        next_mode_fr    = mode_fr;
        next_mode_boost = mode_boost;
        next_chan       = chan;
        next_func       = func;
        next_dir        = dir;
        next_prdata     = O_PRDATA;
        next_pready     = setup;
        next_pslverr    = 1'b0;
        if (wr_ok && hit_mode) begin
            next_mode_run   = I_PWDATA[sar_adc_pkg::MODE_RUN_BIT];
            next_mode_fr    = I_PWDATA[sar_adc_pkg::MODE_FR_LSB +: 3];
            next_mode_boost = I_PWDATA[sar_adc_pkg::MODE_BOOST_BIT];
        end
        if (wr_ok && hit_chan) begin
            next_chan = I_PWDATA[1:0];
        end
        if (wr_ok && I_PADDR == sar_adc_pkg::ADDR_PORT_FUNC) begin
            next_func = I_PWDATA[3:0];
        end
        if (wr_ok && I_PADDR == sar_adc_pkg::ADDR_PORT_DIR) begin
            next_dir = I_PWDATA[3:0];
        end
        if (setup) begin
            next_prdata = 32'h0000_0000;
            case (I_PADDR)
                sar_adc_pkg::ADDR_MODE: begin
                    next_prdata[7:0] = {mode_run, 1'b0, mode_fr, 2'b00, mode_boost};
                end
                sar_adc_pkg::ADDR_CHAN:      next_prdata[7:0] = {6'h00, chan};
                sar_adc_pkg::ADDR_PORT_FUNC: next_prdata[7:0] = {4'h0, func};
                sar_adc_pkg::ADDR_PORT_DIR:  next_prdata[7:0] = {4'hf, dir};
                // wide result, whole 16-bit word, upper six zero
                sar_adc_pkg::ADDR_RESULT_WIDE: begin
                    next_prdata[15:0] = {6'h00, result};
                    next_pslverr      = I_PWRITE;
                end
                sar_adc_pkg::ADDR_RESULT_HIGH: begin
                    next_prdata[7:0] = result[9:2];
                    next_pslverr     = I_PWRITE;
                end
                default: next_pslverr = 1'b1;
            endcase
        end
        // output buffer on only for a digital pin set to output
        next_pin_oe = ~next_dir & ~next_func;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            mode_run     <= sar_adc_pkg::MODE_RST[sar_adc_pkg::MODE_RUN_BIT];
            mode_fr      <= sar_adc_pkg::MODE_RST[sar_adc_pkg::MODE_FR_LSB +: 3];
            mode_boost   <= sar_adc_pkg::MODE_RST[sar_adc_pkg::MODE_BOOST_BIT];
            chan         <= sar_adc_pkg::CHAN_RST[1:0];
            func         <= sar_adc_pkg::PORT_FUNC_RST[3:0];
            dir          <= sar_adc_pkg::PORT_DIR_RST[3:0];
            O_PRDATA     <= 32'h0000_0000;
            O_PREADY     <= 1'b0;
            O_PSLVERR    <= 1'b0;
            O_PIN_OUT_EN <= 4'h0;
        end else begin
            mode_run     <= next_mode_run;
            mode_fr      <= next_mode_fr;
            mode_boost   <= next_mode_boost;
            chan         <= next_chan;
            func         <= next_func;
            dir          <= next_dir;
            O_PRDATA     <= next_prdata;
            O_PREADY     <= next_pready;
            O_PSLVERR    <= next_pslverr;
            O_PIN_OUT_EN <= next_pin_oe;
        end
    end

    // reference generator follows boost bit, pins follow their bits
    always_comb begin
        O_REF_ENABLE = mode_boost;
        O_CHANNEL    = chan;
        O_PIN_ANALOG = func;
    end

    // ------------------------------------------------------------------
    // conversion sequencer
    // ------------------------------------------------------------------
    sar_adc_pkg::conv_state_e state;
    sar_adc_pkg::conv_state_e next_state;
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic [9:0] next_tap;
    logic [9:0] next_result;
    logic       next_done;
    logic       next_sample;
    logic [7:0] sample_ticks;
    logic [7:0] convert_ticks;
    logic [1:0] trial_shift;
    logic [7:0] trial_idx;
    logic [7:0] trial_pos;
    logic [7:0] trial_mask;
    logic [3:0] bit_pos;

    sar_time_table u_time (
        .i_code          (mode_fr),
        .o_sample_ticks  (sample_ticks),
        .o_convert_ticks (convert_ticks),
        .o_trial_shift   (trial_shift)
    );

    // O_TAP is the approximation register itself; the ladder taps off it
    always_comb begin
        next_state  = state;
        next_cnt    = cnt;
        next_tap    = O_TAP;
        next_result = result;
        next_done   = 1'b0;
        trial_mask  = (trial_shift == 2'd2) ? 8'h03 : 8'h01;
        trial_idx   = cnt >> trial_shift;
        trial_pos   = cnt & trial_mask;
        bit_pos     = 4'h9 - trial_idx[3:0];
        if (ctl_write) begin
            // abort, restart a full conversion time if running, no store
            next_state = new_run ? sar_adc_pkg::ST_SAMPLE : sar_adc_pkg::ST_IDLE;
            next_cnt   = 8'h00;
            next_tap   = 10'h000;
        end else if (!mode_run) begin
            // stop at once; idle whenever run is clear
            next_state = sar_adc_pkg::ST_IDLE;
            next_cnt   = 8'h00;
        end else begin
            case (state)
                sar_adc_pkg::ST_IDLE: begin
                    next_state = sar_adc_pkg::ST_SAMPLE;
                    next_cnt   = 8'h00;
                    next_tap   = 10'h000;
                end
                sar_adc_pkg::ST_SAMPLE: begin
                    // sample for the configured ticks, then hold
                    if (tick) begin
                        if (cnt == sample_ticks - 8'h01) begin
                            next_state = sar_adc_pkg::ST_CONVERT;
                            next_cnt   = 8'h00;
                        end else begin
                            next_cnt = cnt + 8'h01;
                        end
                    end
                end
                sar_adc_pkg::ST_CONVERT: begin
                    if (tick) begin
                        next_cnt = cnt + 8'h01;
                        // set trial bit, then keep it only if input >= tap
                        if (trial_idx < 8'(sar_adc_pkg::RESULT_BITS)) begin
                            if (trial_pos == 8'h00) begin
                                next_tap[bit_pos] = 1'b1;
                            end else if (trial_pos == trial_mask && !I_CMP_GE) begin
                                next_tap[bit_pos] = 1'b0;
                            end
                        end
                        // store, pulse done, begin next sample
                        if (cnt == convert_ticks - 8'h01) begin
                            next_result = O_TAP;
                            next_done   = 1'b1;
                            next_state  = sar_adc_pkg::ST_SAMPLE;
                            next_cnt    = 8'h00;
                            next_tap    = 10'h000;
                        end
                    end
                end
                default: begin
                    next_state = sar_adc_pkg::ST_IDLE;
                    next_cnt   = 8'h00;
                end
            endcase
        end
        next_sample = (next_state == sar_adc_pkg::ST_SAMPLE);
    end

    // result reset to zero stands for the undefined power-up content
    always_ff @(posedge I_CORE_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state       <= sar_adc_pkg::ST_IDLE;
            cnt         <= 8'h00;
            O_TAP       <= 10'h000;
            result      <= 10'h000;
            O_CONV_DONE <= 1'b0;
            O_SAMPLE    <= 1'b0;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            O_TAP       <= next_tap;
            result      <= next_result;
            O_CONV_DONE <= next_done;
            O_SAMPLE    <= next_sample;
        end
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);

    sequence s_sample_end;
        state == sar_adc_pkg::ST_SAMPLE && tick && mode_run && !ctl_write
            && cnt == sample_ticks - 8'h01;
    endsequence

    sequence s_first_trial;
        state == sar_adc_pkg::ST_CONVERT && tick && mode_run && !ctl_write && cnt == 8'h00;
    endsequence

    a_done_single_pulse: assert property (O_CONV_DONE |=> !O_CONV_DONE)
        else $error("done request longer than one cycle");
    a_done_stores_sar: assert property (O_CONV_DONE |-> result == $past(O_TAP))
        else $error("stored result differs from approximation value");
    a_repeat_sampling: assert property (O_CONV_DONE |-> O_SAMPLE && cnt == 8'h00)
        else $error("next conversion did not start after done");
    a_hold_after_sample: assert property (s_sample_end |=> !O_SAMPLE ##1 !O_SAMPLE)
        else $error("sampling did not end after configured time");
    a_msb_trial_first: assert property (s_first_trial |=> O_TAP == 10'h200)
        else $error("first trial is not bit 9 alone");
    a_abort_restart: assert property (ctl_write && new_run |=> O_SAMPLE && cnt == 8'h00
                                      && !O_CONV_DONE)
        else $error("control write did not restart conversion");
    a_stop_at_once: assert property (!mode_run && !ctl_write |=> !O_SAMPLE && !O_CONV_DONE
                                     && state == sar_adc_pkg::ST_IDLE)
        else $error("conversion continued with run bit clear");
    a_chan_upper_zero: assert property (setup && !I_PWRITE && hit_chan
                                        |=> O_PRDATA[31:2] == 30'h0)
        else $error("channel register upper bits not zero");
    a_dir_upper_one: assert property (setup && !I_PWRITE
                                      && I_PADDR == sar_adc_pkg::ADDR_PORT_DIR
                                      |=> O_PRDATA[7:4] == 4'hf)
        else $error("direction register upper bits not one");

endmodule
`default_nettype wire

// [src/sar_time_table.sv]
/*
 * Conversion-time lookup: sampling and comparison lengths in peripheral
 * ticks for a conversion-time select code, plus the log2 of one bit trial.
 * Assumes the code is stable while a conversion runs.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_time_table (
    input  wire logic [2:0] i_code,
    output logic      [7:0] o_sample_ticks,
    output logic      [7:0] o_convert_ticks,
    output logic      [1:0] o_trial_shift
);

    // comparison phase is total minus sampling: 24 or 48 ticks, so a
    // trial of 2 or 4 ticks fits ten trials and leaves room to store
    always_comb begin
        o_sample_ticks  = sar_adc_pkg::SAMPLE_TICKS[i_code];
        o_convert_ticks = sar_adc_pkg::TOTAL_TICKS[i_code] - sar_adc_pkg::SAMPLE_TICKS[i_code];
        o_trial_shift   = i_code[2] ? 2'd2 : 2'd1;
    end

endmodule
`default_nettype wire

// [tb/sar_adc_sequencer_tb.sv]
/*
 * Self-checking bench of the converter sequencer: APB register access,
 * conversions on all channels, timing of every time code, abort and stop.
 * Assumes the package constants and a comparator model on the far side.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_adc_sequencer_tb;
    localparam int DIV = 2;
    localparam int T_TICKS [8] = '{36, 48, 72, 112, 72, 96, 144, 224};
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, ge, smp, ref_en, done, err;
    logic [17:0] paddr;
    logic [31:0] pwdata, prdata, rd, v;
    logic [3:0]  pstrb, pin_an, pin_oe;
    logic [9:0]  tap;
    logic [1:0]  chan;
    logic [39:0] levels;
    int          n_mismatch, checked, seed, cyc, lvl, m_dir, m_func, n;
    int          exp_q[$];

    sar_adc_sequencer #(.FXP_DIV(DIV)) u_dut (
        .I_CORE_CLK(clk), .I_NRST(nrst), .I_PSEL(psel), .I_PENABLE(penable),
        .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .I_PSTRB(pstrb),
        .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr), .I_CMP_GE(ge),
        .O_TAP(tap), .O_SAMPLE(smp), .O_CHANNEL(chan), .O_REF_ENABLE(ref_en),
        .O_CONV_DONE(done), .O_PIN_ANALOG(pin_an), .O_PIN_OUT_EN(pin_oe));

    sar_cmp_model u_cmp (.i_clk(clk), .i_levels(levels), .i_channel(chan),
        .i_sample(smp), .i_tap(tap), .o_ge(ge));

    always #2 clk = ~clk;

    // ------------------------------------------------------------------
    // compare, bus and wait tasks
    // ------------------------------------------------------------------
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic chk_time(input int got, input int lo, input int hi, input string what);
        checked++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("unexpected at %0t: %s took %0d cycles", $time, what, got);
        end
    endtask

    // one transfer: held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [17:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && k < 50) begin
            @(posedge clk);
            k++;
        end
        chk_time(k, 0, 49, "bus answer");
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic rdchk(input logic [17:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        chk_val({31'h0, err}, 32'h0, what);
        chk_val(rd, exp, what);
    endtask

    // counts edges up to the done pulse, then checks the pulse is one cycle
    task automatic wait_done();
        cyc = 0;
        @(posedge clk);
        while (done !== 1'b1 && cyc < 1000) begin
            @(posedge clk);
            cyc++;
        end
        chk_time(cyc, 0, 999, "done wait");
        @(posedge clk);
        chk_val({31'h0, done}, 32'h0, "done width");
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // watchdog: the whole sequence needs well under 40000 cycles
    // ------------------------------------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        n_mismatch++;
        results();
    end

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        {clk, nrst, psel, penable, pwrite, paddr, pwdata, levels} = '0;
        {n_mismatch, checked} = '0;
        pstrb = 4'hf;
        seed = 35;
        m_dir = 'hff;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rdchk(sar_adc_pkg::ADDR_MODE, 32'h0, "mode reset");
        rdchk(sar_adc_pkg::ADDR_CHAN, 32'h0, "chan reset");
        rdchk(sar_adc_pkg::ADDR_PORT_FUNC, 32'h0, "func reset");
        rdchk(sar_adc_pkg::ADDR_PORT_DIR, 32'hff, "dir reset");
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            m_dir = v[7:0] | 8'hf0;
            m_func = v[11:8];
            apb(1'b1, sar_adc_pkg::ADDR_PORT_DIR, {24'h0, v[7:0]});
            apb(1'b1, sar_adc_pkg::ADDR_PORT_FUNC, {28'h0, v[11:8]});
            rdchk(sar_adc_pkg::ADDR_PORT_DIR, m_dir, "dir");
            rdchk(sar_adc_pkg::ADDR_PORT_FUNC, m_func, "func");
            chk_val(pin_an, m_func, "pin analog");
            chk_val(pin_oe, ~m_dir & ~m_func & 'hf, "pin drive");
        end
        pstrb <= 4'h0;
        apb(1'b1, sar_adc_pkg::ADDR_PORT_DIR, 32'h0);
        pstrb <= 4'hf;
        rdchk(sar_adc_pkg::ADDR_PORT_DIR, m_dir, "strobe off");
        apb(1'b0, 18'h00100, 32'h0);
        chk_val({err, rd[30:0]}, 32'h80000000, "unmapped");
        apb(1'b1, sar_adc_pkg::ADDR_RESULT_WIDE, 32'h3ff);
        chk_val({31'h0, err}, 32'h1, "result write");
        // analog pins: function and direction set; boost settles 1 us
        apb(1'b1, sar_adc_pkg::ADDR_PORT_FUNC, 32'hf);
        apb(1'b1, sar_adc_pkg::ADDR_PORT_DIR, 32'hff);
        apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h01);
        repeat (260) @(posedge clk);
        for (int c = 0; c < 4; c++) begin
            lvl = $random(seed) & 'h3ff;
            levels[c*10 +: 10] <= lvl[9:0];
            exp_q.push_back(lvl);
            apb(1'b1, sar_adc_pkg::ADDR_CHAN, c);
            apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h81);
            wait_done();
            chk_val(chan, c, "channel out");
            chk_val(ref_en, 1, "boost on");
            rdchk(sar_adc_pkg::ADDR_RESULT_WIDE, exp_q[c], "wide result");
            rdchk(sar_adc_pkg::ADDR_RESULT_HIGH, exp_q[c] >> 2, "high result");
        end
        // every time code: back-to-back conversions spaced by the total time;
        // the code is only changed while conversion is stopped
        for (int k = 0; k < 8; k++) begin
            apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h01 | (k << 3));
            apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h81 | (k << 3));
            wait_done();
            wait_done();
            chk_time(cyc + 2, DIV * T_TICKS[k], DIV * T_TICKS[k], "repeat");
            rdchk(sar_adc_pkg::ADDR_RESULT_WIDE, exp_q[3], "code result");
            apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h01 | (k << 3));
            rdchk(sar_adc_pkg::ADDR_MODE, 32'h01 | (k << 3), "mode fields");
        end
        // late channel write aborts; next done one conversion time after it
        apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h01);
        apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h81);
        wait_done();
        repeat (DIV * 36 - 12) @(posedge clk);
        apb(1'b1, sar_adc_pkg::ADDR_CHAN, 2);
        wait_done();
        chk_time(cyc + 1, DIV * 35, DIV * 37, "abort restart");
        rdchk(sar_adc_pkg::ADDR_RESULT_WIDE, exp_q[2], "after abort");
        // clearing run mid-conversion stops at once, boost left waiting
        repeat (20) @(posedge clk);
        apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h01);
        n = 0;
        repeat (DIV * 80) begin
            @(posedge clk);
            n += (done === 1'b1);
        end
        chk_val(n, 0, "no done stopped");
        chk_val({ref_en, smp}, 2'b10, "waiting state");
        // boost clear with run set still converts
        apb(1'b1, sar_adc_pkg::ADDR_MODE, 32'h80);
        wait_done();
        chk_val(ref_en, 0, "boost off");
        results();
    end
endmodule

`default_nettype wire

// [tb/sar_cmp_model.sv]
/*
 * Behavioural comparator and ladder tap selector facing the sequencer.
 * Assumes the tap follows the sequencer's tap code with no delay and that
 * each input level is held steady by the bench while it is sampled.
 */
`timescale 1ns/1ps
`default_nettype none

module sar_cmp_model (
    input  wire logic        i_clk,
    input  wire logic [39:0] i_levels,
    input  wire logic [1:0]  i_channel,
    input  wire logic        i_sample,
    input  wire logic [9:0]  i_tap,
    output logic             o_ge
);
    logic [9:0] held = 10'h155;

    // ------------------------------------------------------------------
    // sample and hold, then compare
    // ------------------------------------------------------------------
    // track then hold
    always @(posedge i_clk) begin
        if (i_sample) begin
            held <= i_levels[i_channel*10 +: 10];
        end
    end

    // input at or above tap; answers at once, as a real comparator
    assign o_ge = (held >= i_tap);
endmodule

`default_nettype wire
